// *** core/asm_pkg.sv ***
// Package with register map, field layout and carrier types for the amplifier status monitor
// Contract
// - Bits 6:4 of the channel 0 mode monitor at 0x60 show channel 0's live switching rate.
// - Bits 1:0 of the channel 0 mode monitor show channel 0's live power profile.
// - Bit 5 of the channel 0 protection monitor at 0x61 shows whether channel 0 is muted.
// - Bit 4 of the channel 0 protection monitor shows whether channel 0's core supply is good.
// - Bit 3 of the channel 0 protection monitor shows whether channel 0's power stage supply is good.
// - Bits 2 and 1 of the channel 0 protection monitor show the second and first flying cap good.
// - Bit 0 of the channel 0 protection monitor shows that an over-current event occurred.
// - Each channel's modulation index register holds the live 8-bit index, 0 to 1 onto 0 to 255.
// - Channel 1 has the same three monitor registers at 0x64, 0x65 and 0x66.
// - Each bit of the sticky fault register at 0x6d sets and holds when its fault source fires.
// - The sticky fault register is cleared only by the fault handler clear control.
// - The fault handler clear is bit 2 at 0x2d and clears on a full low-high-low toggle.
// - The live fault register at 0x7c shows each fault source's current state, 1 when active.
// - Fault bits are 0 flycap overvoltage, 1 overcurrent, 2 clock synth, 3 supply UV, 4 OT warn, 5 OT error, 6 pin short, 7 DC.
// - Bits 2:0 of the output configuration monitor at 0x75 reflect the configuration select pins.
package asm_pkg;
	localparam logic [7:0] ASM_ADDR_CH0_MODE = 8'h60;
	localparam logic [7:0] ASM_ADDR_CH0_PROT = 8'h61;
	localparam logic [7:0] ASM_ADDR_CH0_MIDX = 8'h62;
	localparam logic [7:0] ASM_ADDR_CH1_MODE = 8'h64;
	localparam logic [7:0] ASM_ADDR_CH1_PROT = 8'h65;
	localparam logic [7:0] ASM_ADDR_CH1_MIDX = 8'h66;
	localparam logic [7:0] ASM_ADDR_STICKY = 8'h6d;
	localparam logic [7:0] ASM_ADDR_OUTCFG = 8'h75;
	localparam logic [7:0] ASM_ADDR_LIVE = 8'h7c;
	localparam logic [7:0] ASM_ADDR_CLEAR = 8'h2d;
	localparam int ASM_CLEAR_BIT = 2;
	localparam logic [7:0] ASM_REG_RESET = 8'h00;
	localparam int ASM_NUM_CH = 2;
	// Fault bit positions, shared by the live and sticky registers
	localparam int ASM_FLT_FLYCAP_OV = 0;
	localparam int ASM_FLT_OVERCURRENT = 1;
	localparam int ASM_FLT_CLK_SYNTH = 2;
	localparam int ASM_FLT_SUPPLY_UV = 3;
	localparam int ASM_FLT_OT_WARN = 4;
	localparam int ASM_FLT_OT_ERR = 5;
	localparam int ASM_FLT_PIN_SHORT = 6;
	localparam int ASM_FLT_DC = 7;

	// Live state of one channel, as delivered by the power management core
	typedef struct packed {
		logic [2:0] switching_rate_state;
		logic [1:0] power_profile_state;
		logic muted;
		logic core_supply_good;
		logic power_stage_supply_good;
		logic second_flying_cap_good;
		logic first_flying_cap_good;
		logic overcurrent_event;
		logic [7:0] modulation_index;
	} asm_ch_status_t;

	// Register host port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} asm_reg_req_t;

	// Clear toggle tracking states: Gray order wait for low, armed, high seen
	typedef enum logic [1:0] {
		ASM_CLR_WAIT_LOW = 2'b00,
		ASM_CLR_ARMED = 2'b01,
		ASM_CLR_HIGH = 2'b11
	} asm_clr_state_t;
endpackage

// *** core/asm_ch_regs.sv ***
// Formats one channel's live state into its three monitor register images
`timescale 1ns/1ns
module asm_ch_regs
	import asm_pkg::*;
(
	input wire logic clock_i,
	input wire logic srst_i,
	input asm_pkg::asm_ch_status_t status_i,
	output logic [7:0] mode_o,
	output logic [7:0] prot_o,
	output logic [7:0] midx_o
);
	typedef struct packed {
		logic [7:0] mode;
		logic [7:0] prot;
		logic [7:0] midx;
	} asm_ch_state_t;

	asm_ch_state_t state_ff;
	asm_ch_state_t nxt_state;

	// Capture the live state each cycle into the register images
	always_comb
	begin
		nxt_state = state_ff;
		nxt_state.mode = {1'b0, status_i.switching_rate_state, 2'b00,
			status_i.power_profile_state};
		nxt_state.prot = {2'b00, status_i.muted,
			status_i.core_supply_good,
			status_i.power_stage_supply_good,
			status_i.second_flying_cap_good, status_i.first_flying_cap_good,
			status_i.overcurrent_event};
		nxt_state.midx = status_i.modulation_index;
	end

	// State register, zero after reset
	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			state_ff <= '0;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	assign mode_o = state_ff.mode;
	assign prot_o = state_ff.prot;
	assign midx_o = state_ff.midx;

	mode_follow_a: assert property (@(posedge clock_i) disable iff (srst_i)
		!$past(srst_i) |-> mode_o[6:4] == $past(status_i.switching_rate_state)
		&& mode_o[1:0] == $past(status_i.power_profile_state))
		else $error("mode monitor does not follow live state");
	prot_follow_a: assert property (@(posedge clock_i) disable iff (srst_i)
		!$past(srst_i) |-> prot_o[5] == $past(status_i.muted)
		&& prot_o[0] == $past(status_i.overcurrent_event))
		else $error("protection monitor does not follow live state");
	midx_follow_a: assert property (@(posedge clock_i) disable iff (srst_i)
		!$past(srst_i) |-> midx_o == $past(status_i.modulation_index))
		else $error("modulation index not live");
endmodule

// *** core/asm_fault_acc.sv ***
// Sticky fault accumulator with toggle-driven clear
`timescale 1ns/1ns
module asm_fault_acc
	import asm_pkg::*;
#(
	parameter int WIDTH = 8
)
(
	input wire logic clock_i,
	input wire logic srst_i,
	input wire logic [WIDTH-1:0] live_i,
	input wire logic clear_level_i,
	output logic [WIDTH-1:0] sticky_o,
	output logic clear_pulse_o
);
	typedef struct packed {
		asm_clr_state_t clr;
		logic [WIDTH-1:0] sticky;
	} asm_acc_state_t;

	asm_acc_state_t state_ff;
	asm_acc_state_t nxt_state;
	logic clr_now;

	// Track low, high, low on the clear bit; the falling edge clears
	always_comb
	begin
		nxt_state = state_ff;
		clr_now = 1'b0;
		case (state_ff.clr)
			ASM_CLR_WAIT_LOW:
			begin
				if (!clear_level_i)
				begin
					nxt_state.clr = ASM_CLR_ARMED;
				end
			end
			ASM_CLR_ARMED:
			begin
				if (clear_level_i)
				begin
					nxt_state.clr = ASM_CLR_HIGH;
				end
			end
			ASM_CLR_HIGH:
			begin
				if (!clear_level_i)
				begin
					nxt_state.clr = ASM_CLR_ARMED;
					clr_now = 1'b1;
				end
			end
			default:
			begin
				nxt_state.clr = ASM_CLR_WAIT_LOW;
			end
		endcase
		// Clear only through the toggle; a fault in the same cycle still sets
		nxt_state.sticky = (clr_now ? '0 : state_ff.sticky) | live_i;
	end

	// State register
	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			state_ff <= '{clr: ASM_CLR_WAIT_LOW, sticky: '0};
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	assign sticky_o = state_ff.sticky;
	assign clear_pulse_o = clr_now;

	// Low then high on the clear bit
	sequence clr_rise_s;
		!clear_level_i ##1 clear_level_i;
	endsequence
	// Low, high for two cycles, then low again, as two back-to-back writes give
	sequence clr_toggle_s;
		!clear_level_i ##1 clear_level_i [*2] ##1 !clear_level_i;
	endsequence
	clear_armed_a: assert property (@(posedge clock_i) disable iff (srst_i)
		clr_rise_s |=> state_ff.clr == ASM_CLR_HIGH)
		else $error("rising clear bit not tracked");
	sticky_hold_a: assert property (@(posedge clock_i) disable iff (srst_i)
		!clr_now |=> (sticky_o & $past(state_ff.sticky)) == $past(state_ff.sticky))
		else $error("sticky bit lost without clear");
	sticky_set_a: assert property (@(posedge clock_i) disable iff (srst_i)
		(|live_i) |=> (sticky_o & $past(live_i)) == $past(live_i))
		else $error("fault not accumulated");
	clear_toggle_a: assert property (@(posedge clock_i) disable iff (srst_i)
		clr_toggle_s |-> clr_now)
		else $error("toggle did not clear");
	clear_only_a: assert property (@(posedge clock_i) disable iff (srst_i)
		clr_now |-> $past(clear_level_i) && !clear_level_i)
		else $error("clear without toggle");
endmodule

// *** core/asm_status_monitor.sv ***
// Top of the read-only status and fault monitor register bank
`timescale 1ns/1ns
module asm_status_monitor
	import asm_pkg::*;
(
	input wire logic clock_i,
	input wire logic srst_i,
	input asm_pkg::asm_ch_status_t ch0_status_i,
	input asm_pkg::asm_ch_status_t ch1_status_i,
	input wire logic [7:0] fault_live_i,
	input wire logic [2:0] output_config_sel_i,
	input asm_pkg::asm_reg_req_t reg_req_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o,
	output logic fault_clear_pulse_o
);
	typedef struct packed {
		logic clear_level;
		logic [7:0] live;
		logic [7:0] outcfg;
		logic [7:0] rdata;
		logic rvalid;
	} asm_top_state_t;

	asm_top_state_t state_ff;
	asm_top_state_t nxt_state;
	logic [7:0] ch_mode [ASM_NUM_CH];
	logic [7:0] ch_prot [ASM_NUM_CH];
	logic [7:0] ch_midx [ASM_NUM_CH];
	asm_ch_status_t ch_status [ASM_NUM_CH];
	logic [7:0] sticky;

	assign ch_status[0] = ch0_status_i;
	assign ch_status[1] = ch1_status_i;

	// One formatter per channel, same layout for both
	for (genvar c = 0; c < ASM_NUM_CH; c++)
	begin : g_ch
		asm_ch_regs u_ch (
			.clock_i(clock_i),
			.srst_i(srst_i),
			.status_i(ch_status[c]),
			.mode_o(ch_mode[c]),
			.prot_o(ch_prot[c]),
			.midx_o(ch_midx[c])
		);
	end

	asm_fault_acc #(.WIDTH(8)) u_acc (
		.clock_i(clock_i),
		.srst_i(srst_i),
		.live_i(state_ff.live),
		.clear_level_i(state_ff.clear_level),
		.sticky_o(sticky),
		.clear_pulse_o(fault_clear_pulse_o)
	);

	// Register capture, clear-bit writes and read decode
	always_comb
	begin
		nxt_state = state_ff;
		nxt_state.live = fault_live_i;
		nxt_state.outcfg = {5'h00, output_config_sel_i};
		nxt_state.rvalid = reg_req_i.rd;
		// Writes reach only the clear control; monitor registers ignore them
		if (reg_req_i.wr && reg_req_i.addr == ASM_ADDR_CLEAR)
		begin
			nxt_state.clear_level = reg_req_i.wdata[ASM_CLEAR_BIT];
		end
		if (!reg_req_i.rd)
		begin
			nxt_state.rdata = state_ff.rdata;
		end
		else if (reg_req_i.addr == ASM_ADDR_CH0_MODE)
		begin
			nxt_state.rdata = ch_mode[0];
		end
		else if (reg_req_i.addr == ASM_ADDR_CH0_PROT)
		begin
			nxt_state.rdata = ch_prot[0];
		end
		else if (reg_req_i.addr == ASM_ADDR_CH0_MIDX)
		begin
			nxt_state.rdata = ch_midx[0];
		end
		else if (reg_req_i.addr == ASM_ADDR_CH1_MODE)
		begin
			nxt_state.rdata = ch_mode[1];
		end
		else if (reg_req_i.addr == ASM_ADDR_CH1_PROT)
		begin
			nxt_state.rdata = ch_prot[1];
		end
		else if (reg_req_i.addr == ASM_ADDR_CH1_MIDX)
		begin
			nxt_state.rdata = ch_midx[1];
		end
		else if (reg_req_i.addr == ASM_ADDR_STICKY)
		begin
			nxt_state.rdata = sticky;
		end
		else if (reg_req_i.addr == ASM_ADDR_OUTCFG)
		begin
			nxt_state.rdata = state_ff.outcfg;
		end
		else if (reg_req_i.addr == ASM_ADDR_LIVE)
		begin
			nxt_state.rdata = state_ff.live;
		end
		else if (reg_req_i.addr == ASM_ADDR_CLEAR)
		begin
			nxt_state.rdata = {5'h00, state_ff.clear_level, 2'b00};
		end
		else
		begin
			nxt_state.rdata = ASM_REG_RESET;
		end
	end

	// State register
	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			state_ff <= '0;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	assign reg_rdata_o = state_ff.rdata;
	assign reg_rvalid_o = state_ff.rvalid;

	read_latency_a: assert property (@(posedge clock_i) disable iff (srst_i)
		reg_req_i.rd |=> reg_rvalid_o)
		else $error("read answer missing");
	live_read_a: assert property (@(posedge clock_i) disable iff (srst_i)
		reg_req_i.rd && reg_req_i.addr == ASM_ADDR_LIVE |=>
		reg_rdata_o == $past(state_ff.live))
		else $error("live fault read wrong");
	outcfg_read_a: assert property (@(posedge clock_i) disable iff (srst_i)
		reg_req_i.rd && reg_req_i.addr == ASM_ADDR_OUTCFG |=>
		reg_rdata_o == {5'h00, $past(output_config_sel_i, 2)})
		else $error("output config read wrong");
	sticky_read_a: assert property (@(posedge clock_i) disable iff (srst_i)
		reg_req_i.rd && reg_req_i.addr == ASM_ADDR_STICKY |=>
		reg_rdata_o == $past(sticky))
		else $error("sticky read wrong");
	reset_zero_a: assert property (@(posedge clock_i)
		srst_i |=> reg_rdata_o == ASM_REG_RESET && !reg_rvalid_o)
		else $error("read data not zero after reset");
endmodule

// *** verif/asm_host_model.sv ***
// Host model that issues register reads and writes on the request port
`timescale 1ns/1ns
module asm_host_model
	import asm_pkg::*;
(
	input wire logic clock_i,
	input wire logic [7:0] rdata_i,
	input wire logic rvalid_i,
	output asm_pkg::asm_reg_req_t req_o
);
	initial req_o = '0;

	// One write strobe; released bus fields show the inverse so stale values never match
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clock_i);
		req_o.wr <= 1'b0;
		req_o.addr <= ~a;
		req_o.wdata <= ~d;
		@(posedge clock_i);
	endtask

	// One read strobe; the answer is taken at the edge after the strobe is sampled
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clock_i);
		req_o.rd <= 1'b0;
		req_o.addr <= ~a;
		@(posedge clock_i);
		ok = rvalid_i;
		d = rdata_i;
	endtask
endmodule

// *** verif/tb_asm_status_monitor.sv ***
// Self-checking testbench for the status monitor register bank
`timescale 1ns/1ns
module tb_asm_status_monitor;
	import asm_pkg::*;
	logic clock_i = 1'b0;
	logic srst_i = 1'b1;
	asm_ch_status_t ch0 = '0;
	asm_ch_status_t ch1 = '0;
	logic [7:0] flt = 8'h00;
	logic [2:0] sel = 3'h0;
	asm_reg_req_t req;
	logic [7:0] rdata;
	logic rvalid;
	logic clr_pulse;
	int fail_count = 0;
	int num_checks = 0;
	int pulses = 0;
	logic [7:0] addrs [9] = '{8'h60, 8'h61, 8'h62, 8'h64, 8'h65, 8'h66, 8'h6d, 8'h75, 8'h7c};

	// Clock at 100 MHz
	always #5 clock_i = ~clock_i;

	asm_status_monitor dut (.clock_i(clock_i), .srst_i(srst_i), .ch0_status_i(ch0),
		.ch1_status_i(ch1), .fault_live_i(flt), .output_config_sel_i(sel), .reg_req_i(req),
		.reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .fault_clear_pulse_o(clr_pulse));
	asm_host_model host (.clock_i(clock_i), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req));

	// Count completed clear toggles
	always @(posedge clock_i)
	begin
		if (clr_pulse === 1'b1)
			pulses <= pulses + 1;
	end

	// Expected register images built from channel fields
	function automatic logic [7:0] mode_img(asm_ch_status_t s);
		return {1'b0, s.switching_rate_state, 2'b00, s.power_profile_state};
	endfunction
	function automatic logic [7:0] prot_img(asm_ch_status_t s);
		return {2'b00, s.muted, s.core_supply_good, s.power_stage_supply_good,
			s.second_flying_cap_good, s.first_flying_cap_good, s.overcurrent_event};
	endfunction

	// Read one register and compare
	task automatic chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic ok;
		host.rd(a, d, ok);
		num_checks++;
		if (ok !== 1'b1 || d !== exp)
		begin
			fail_count++;
			$display("Error at %0t: addr %h read %h valid %b, expected %h", $time, a, d, ok, exp);
		end
	endtask

	// Zero after reset, writes ignored, unmapped reads zero
	task automatic t_reset();
		foreach (addrs[i])
			chk(addrs[i], 8'h00);
		foreach (addrs[i])
			host.wr(addrs[i], 8'hff);
		foreach (addrs[i])
			chk(addrs[i], 8'h00);
		chk(8'h63, 8'h00);
		$display("Test reset and write-protect done");
	endtask

	// Channel field placement, swapped patterns per channel
	task automatic t_channels();
		asm_ch_status_t p [2];
		p[0] = {3'h6, 2'h2, 6'b101010, 8'hff};
		p[1] = {3'h1, 2'h1, 6'b010101, 8'h5a};
		for (int k = 0; k < 2; k++)
		begin
			ch0 <= p[k];
			ch1 <= p[1-k];
			repeat (3) @(posedge clock_i);
			chk(8'h60, mode_img(p[k]));
			chk(8'h61, prot_img(p[k]));
			chk(8'h62, p[k].modulation_index);
			chk(8'h64, mode_img(p[1-k]));
			chk(8'h65, prot_img(p[1-k]));
			chk(8'h66, p[1-k].modulation_index);
		end
		$display("Test channel monitors done");
	endtask

	// Live and sticky faults, partial and full clear toggles
	task automatic t_faults();
		for (int i = 0; i < 8; i++)
		begin
			flt <= 8'h01 << i;
			repeat (2) @(posedge clock_i);
			chk(8'h7c, 8'h01 << i);
		end
		flt <= 8'h00;
		repeat (3) @(posedge clock_i);
		chk(8'h7c, 8'h00);
		chk(8'h6d, 8'hff);
		host.wr(8'h6d, 8'h00);
		host.wr(8'h2d, 8'h00);
		host.wr(8'h2d, 8'h04);
		chk(8'h2d, 8'h04);
		chk(8'h6d, 8'hff);
		host.wr(8'h2d, 8'h00);
		repeat (2) @(posedge clock_i);
		chk(8'h6d, 8'h00);
		// A fault still live during the clear keeps its sticky bit
		flt <= 8'h02;
		host.wr(8'h2d, 8'h04);
		host.wr(8'h2d, 8'h00);
		repeat (2) @(posedge clock_i);
		chk(8'h6d, 8'h02);
		flt <= 8'h00;
		num_checks++;
		if (pulses !== 2)
		begin
			fail_count++;
			$display("Error at %0t: clear pulses %0d, expected 2", $time, pulses);
		end
		$display("Test fault registers done");
	endtask

	// Every configuration select code
	task automatic t_outcfg();
		for (int i = 0; i < 8; i++)
		begin
			sel <= 3'(i);
			repeat (3) @(posedge clock_i);
			chk(8'h75, {5'h00, 3'(i)});
		end
		$display("Test output configuration done");
	endtask

	// Verdict and end of run
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		repeat (10) @(posedge clock_i);
		srst_i <= 1'b0;
		@(posedge clock_i);
		t_reset();
		t_channels();
		t_faults();
		t_outcfg();
		tally_and_finish();
	end

	// Watchdog well beyond the expected few hundred cycles
	initial
	begin
		#50000;
		fail_count++;
		$display("Error at %0t: watchdog expired", $time);
		tally_and_finish();
	end
endmodule
